// ---- logic/serial_rx_path.sv ----
// Receive path of one serial channel with pin direction control and FIFO pool
// Assumes APB master on pclk; serial pins are asynchronous and synchronised here
//
// How it works
// - Two lane register sets, each with own buffer
// - Finished word or frame end copies to buffer
// - Words read in order, merged view or FIFO
// - One, two or four bits per shift
// - Lane code 00, 10, 11 maps bits
// - Bit order setting decides first bit place
// - Hardware direction overrides pins, forces push-pull
// - Enable picks one, two, four pins
// - Direction shadowed at start of each word
// - Pool of 64 shared FIFO entries
// - FIFOs exist only when presence flag set
// - FIFO interrupt bits writable any time
// - Entry holds data plus control info
// - Entries belong to this module only
// - Sizes powers of two from two
// - FIFO aligned, contiguous within its range
// - Pointers advance in hardware
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "serial_rx_regs.svh"

module serial_rx_path
    import serial_rx_pkg::*;
#(
    parameter int POOL_ENTRIES = 64,
    parameter bit TX_PRESENT   = 1'b1,
    parameter bit RX_PRESENT   = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        shift_clk_pin,
    input  wire logic        shift_ctl_pin,
    input  wire logic [3:0]  data_pin_in,
    output logic      [3:0]  pin_oe,
    output logic             pin_hw_ctrl,
    output logic             pin_push_pull
);

    // ************************************************************
    // Checks and helpers
    // ************************************************************
    generate
        if (POOL_ENTRIES != 64) begin : g_bad_pool
            $error("pool size must be 64 entries");
        end
    endgenerate

    function automatic logic [1:0] lane_log(input logic [1:0] code);
        case (code)
            LANE_TWO:  lane_log = 2'd1;
            LANE_FOUR: lane_log = 2'd2;
            default:   lane_log = 2'd0;
        endcase
    endfunction

    function automatic logic [5:0] size_mask(input logic [2:0] code);
        size_mask = 6'((7'd1 << code) - 7'd1);
    endfunction

    function automatic logic [5:0] entry_addr(input logic [5:0] base,
                                              input logic [5:0] off,
                                              input logic [5:0] mask);
        entry_addr = (base & ~mask) | (off & mask);
    endfunction

    function automatic logic [15:0] compose(input logic [15:0] l0,
                                            input logic [15:0] l1,
                                            input logic [15:0] l2,
                                            input logic [15:0] l3,
                                            input logic [1:0]  lg,
                                            input logic [3:0]  wl,
                                            input logic        msb);
        logic [15:0] w;
        logic [3:0]  n;
        logic [1:0]  k;
        logic        b;
        w = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            case (lg)
                2'd1:    k = {1'b0, 1'(i)};
                2'd2:    k = 2'(i);
                default: k = 2'd0;
            endcase
            n = 4'(i >> lg);
            case (k)
                2'd0:    b = l0[n];
                2'd1:    b = l1[n];
                2'd2:    b = l2[n];
                default: b = l3[n];
            endcase
            if (4'(i) <= wl) begin
                if (msb) begin
                    w[wl - 4'(i)] = b;
                end else begin
                    w[i] = b;
                end
            end
        end
        compose = w;
    endfunction

    function automatic logic [3:0] pin_mask(input logic [1:0] en);
        case (en)
            2'b01:   pin_mask = 4'h1;
            2'b10:   pin_mask = 4'h3;
            2'b11:   pin_mask = 4'hF;
            default: pin_mask = 4'h0;
        endcase
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic        sclk_prev;
    logic        ctl_prev;
    logic [31:0] shift_ctrl;
    logic [31:0] chan_ctrl;
    logic [31:0] rx_fifo_ctrl;
    logic [31:0] tx_fifo_ctrl;
    rx_state_t   state;
    logic [4:0]  shift_cnt;
    logic        bank;
    logic [15:0] shift_reg_lane0 [2];
    logic [15:0] shift_reg_lane1 [2];
    logic [15:0] shift_reg_lane2 [2];
    logic [15:0] shift_reg_lane3 [2];
    logic        copy_req;
    logic        copy_bank;
    logic        copy_eof;
    logic [3:0]  copy_wl;
    logic [15:0] receive_buffer_a;
    logic [15:0] receive_buffer_b;
    logic [4:0]  rci_a;
    logic [4:0]  rci_b;
    logic [1:0]  buf_valid;
    logic        rd_bank;
    logic        shadow_dir;
    fifo_entry_t pool [POOL_ENTRIES];
    logic [5:0]  rx_rd_off;
    logic [5:0]  rx_wr_off;
    logic [6:0]  rx_fill;

    // ************************************************************
    // Decode
    // ************************************************************
    wire        shift_evt   = sync2[5] & ~sclk_prev;
    wire        ctl_act     = sync2[4];
    wire [3:0]  din         = sync2[3:0];
    wire        frame_end   = ~ctl_act & ctl_prev;
    wire [1:0]  lg          = lane_log(shift_ctrl[`SC_LANE_MSB:`SC_LANE_LSB]);
    wire [3:0]  wlen        = shift_ctrl[`SC_WLEN_MSB:`SC_WLEN_LSB];
    wire [4:0]  per_word    = 5'(({1'b0, wlen} + 5'd1) >> lg);
    wire        in_shift    = shift_evt & ctl_act;
    wire        word_done   = in_shift & ((shift_cnt + 5'd1) == per_word);
    wire        part_done   = frame_end & (shift_cnt != 5'd0);
    wire [3:0]  part_wl     = 4'(({1'b0, shift_cnt} << lg) - 6'd1);
    wire [15:0] done_word   = compose(shift_reg_lane0[copy_bank], shift_reg_lane1[copy_bank],
                                      shift_reg_lane2[copy_bank], shift_reg_lane3[copy_bank],
                                      lg, copy_wl, shift_ctrl[`SC_ORDER_BIT]);
    wire [2:0]  rx_size     = rx_fifo_ctrl[`FC_SIZE_MSB:`FC_SIZE_LSB];
    wire        fifo_on     = RX_PRESENT && (rx_size != 3'd0) && (rx_size != 3'd7);
    wire [5:0]  rx_mask     = size_mask(rx_size);
    wire [6:0]  rx_depth    = {1'b0, rx_mask} + 7'd1;
    wire [5:0]  rx_base     = rx_fifo_ctrl[`FC_PTR_MSB:`FC_PTR_LSB];
    wire        rx_full     = rx_fill == rx_depth;
    wire        drain       = fifo_on & buf_valid[rd_bank] & ~rx_full;
    wire [20:0] drain_entry = rd_bank ? {rci_b, receive_buffer_b} : {rci_a, receive_buffer_a};
    wire [20:0] fifo_head   = pool[entry_addr(rx_base, rx_rd_off, rx_mask)];
    wire        apb_first   = psel & penable & ~pready;
    wire        apb_done    = psel & penable & pready;
    wire        hit_sc      = paddr == `OFS_SHIFT_CTRL;
    wire        hit_cc      = paddr == `OFS_CHAN_CTRL;
    wire        hit_cfg     = paddr == `OFS_CHAN_CFG;
    wire        hit_rfc     = paddr == `OFS_RX_FIFO_CTRL;
    wire        hit_tfc     = paddr == `OFS_TX_FIFO_CTRL;
    wire        hit_mrg     = paddr == `OFS_RX_MERGED;
    wire        hit_out     = paddr == `OFS_RX_FIFO_OUT;
    wire        hit_st      = paddr == `OFS_RX_STATUS;
    wire        addr_hit    = |{hit_sc, hit_cc, hit_cfg, hit_rfc, hit_tfc, hit_mrg, hit_out, hit_st};
    wire        rd_done     = apb_done & ~pwrite;
    wire        pop_merged  = rd_done & hit_mrg & ~fifo_on & buf_valid[rd_bank];
    wire        pop_fifo    = rd_done & hit_out & fifo_on & (rx_fill != 7'd0);
    wire        pop_buf     = pop_merged | drain;
    wire        wr_done     = apb_done & pwrite;
    wire        rx_alloc_ok = (rx_size == 3'd0) | (pwdata[`FC_SIZE_MSB:`FC_SIZE_LSB] == 3'd0);
    wire        tx_alloc_ok = (tx_fifo_ctrl[`FC_SIZE_MSB:`FC_SIZE_LSB] == 3'd0)
                            | (pwdata[`FC_SIZE_MSB:`FC_SIZE_LSB] == 3'd0);
    wire [1:0]  set_valid   = {copy_req & copy_bank, copy_req & ~copy_bank};
    wire [1:0]  clr_valid   = {pop_buf & rd_bank, pop_buf & ~rd_bank};
    wire [1:0]  next_valid  = set_valid | (buf_valid & ~clr_valid);
    wire [6:0]  next_fill   = rx_fill + {6'd0, drain} - {6'd0, pop_fifo};
    wire [1:0]  pdc_en      = chan_ctrl[`CC_PDC_MSB:`CC_PDC_LSB];
    wire [31:0] status      = {18'd0, shadow_dir, state == ST_FRAME, 1'b0, rx_fill,
                               1'b0, rd_bank, buf_valid};
    wire [31:0] merged_rd   = rd_bank ? {buf_valid[1], 10'd0, rci_b, receive_buffer_b}
                                      : {buf_valid[0], 10'd0, rci_a, receive_buffer_a};
    wire [31:0] fifo_rd     = {rx_fill != 7'd0, 10'd0, rx_fill != 7'd0 ? fifo_head : 21'd0};
    wire [31:0] rd_mux      = hit_sc  ? shift_ctrl :
                              hit_cc  ? chan_ctrl :
                              hit_cfg ? {30'd0, RX_PRESENT, TX_PRESENT} :
                              hit_rfc ? rx_fifo_ctrl :
                              hit_tfc ? tx_fifo_ctrl :
                              hit_mrg ? merged_rd :
                              hit_out ? fifo_rd :
                              hit_st  ? status : 32'h0000_0000;

    // ************************************************************
    // Pin synchronisers and frame tracking
    // ************************************************************
    // The frame gap and shortest frame limits keep the edges visible after sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1     <= 6'd0;
            sync2     <= 6'd0;
            sclk_prev <= 1'b0;
            ctl_prev  <= 1'b0;
            state     <= ST_IDLE;
        end else begin
            sync1     <= {shift_clk_pin, shift_ctl_pin, data_pin_in};
            sync2     <= sync1;
            sclk_prev <= sync2[5];
            ctl_prev  <= ctl_act;
            state     <= ctl_act ? ST_FRAME : ST_IDLE;
        end
    end

    // ************************************************************
    // Lane shift registers, two sets used alternately
    // ************************************************************
    // A finished set is left alone during the next word, so the copy sees it stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_cnt <= 5'd0;
            bank      <= 1'b0;
            copy_req  <= 1'b0;
            copy_bank <= 1'b0;
            copy_eof  <= 1'b0;
            copy_wl   <= 4'd0;
            for (int s = 0; s < 2; s++) begin
                shift_reg_lane0[s] <= 16'h0000;
                shift_reg_lane1[s] <= 16'h0000;
                shift_reg_lane2[s] <= 16'h0000;
                shift_reg_lane3[s] <= 16'h0000;
            end
        end else begin
            copy_req <= word_done | part_done;
            if (in_shift) begin
                shift_reg_lane0[bank][shift_cnt[3:0]] <= din[0];
                shift_reg_lane1[bank][shift_cnt[3:0]] <= din[1];
                shift_reg_lane2[bank][shift_cnt[3:0]] <= din[2];
                shift_reg_lane3[bank][shift_cnt[3:0]] <= din[3];
            end
            if (word_done) begin
                shift_cnt <= 5'd0;
                bank      <= ~bank;
                copy_bank <= bank;
                copy_wl   <= wlen;
                copy_eof  <= 1'b0;
            end else if (part_done) begin
                shift_cnt <= 5'd0;
                bank      <= ~bank;
                copy_bank <= bank;
                copy_wl   <= part_wl;
                copy_eof  <= 1'b1;
            end else if (in_shift) begin
                shift_cnt <= shift_cnt + 5'd1;
            end
        end
    end

    // ************************************************************
    // Receive buffers and FIFO pool
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_buffer_a <= 16'h0000;
            receive_buffer_b <= 16'h0000;
            rci_a            <= 5'd0;
            rci_b            <= 5'd0;
            buf_valid        <= 2'b00;
            rd_bank          <= 1'b0;
        end else begin
            if (copy_req && !copy_bank) begin
                receive_buffer_a <= done_word;
                rci_a            <= {copy_eof, copy_wl};
            end
            if (copy_req && copy_bank) begin
                receive_buffer_b <= done_word;
                rci_b            <= {copy_eof, copy_wl};
            end
            buf_valid <= next_valid;
            if (pop_buf) begin
                rd_bank <= ~rd_bank;
            end
        end
    end

    // Pool has no reset; entries are only read once written through the fill count
    always_ff @(posedge pclk) begin
        if (drain) begin
            pool[entry_addr(rx_base, rx_wr_off, rx_mask)] <= drain_entry;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_rd_off <= 6'd0;
            rx_wr_off <= 6'd0;
            rx_fill   <= 7'd0;
        end else if (wr_done && hit_rfc && rx_alloc_ok) begin
            rx_rd_off <= 6'd0;
            rx_wr_off <= 6'd0;
            rx_fill   <= 7'd0;
        end else begin
            if (drain) begin
                rx_wr_off <= (rx_wr_off + 6'd1) & rx_mask;
            end
            if (pop_fifo) begin
                rx_rd_off <= (rx_rd_off + 6'd1) & rx_mask;
            end
            rx_fill <= next_fill;
        end
    end

    // ************************************************************
    // Registers and APB slave, one wait state
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_ctrl   <= `SHIFT_CTRL_RESET;
            chan_ctrl    <= `CTRL_RESET;
            rx_fifo_ctrl <= `CTRL_RESET;
            tx_fifo_ctrl <= `CTRL_RESET;
        end else if (wr_done) begin
            if (hit_sc) begin
                shift_ctrl <= {24'd0, pwdata[7:0]};
            end
            if (hit_cc) begin
                chan_ctrl <= {30'd0, pwdata[`CC_PDC_MSB:`CC_PDC_LSB]};
            end
            if (hit_rfc && RX_PRESENT) begin
                rx_fifo_ctrl[`FC_IRQ_MSB:`FC_IRQ_LSB] <= pwdata[`FC_IRQ_MSB:`FC_IRQ_LSB];
                if (rx_alloc_ok) begin
                    rx_fifo_ctrl[`FC_SIZE_MSB:`FC_PTR_LSB] <= {pwdata[10:8], 2'd0, pwdata[5:0]};
                end
            end
            if (hit_tfc && TX_PRESENT) begin
                tx_fifo_ctrl[`FC_IRQ_MSB:`FC_IRQ_LSB] <= pwdata[`FC_IRQ_MSB:`FC_IRQ_LSB];
                if (tx_alloc_ok) begin
                    tx_fifo_ctrl[`FC_SIZE_MSB:`FC_PTR_LSB] <= {pwdata[10:8], 2'd0, pwdata[5:0]};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_first;
            pslverr <= apb_first & ~addr_hit;
            prdata  <= (apb_first && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ************************************************************
    // Hardware pin direction control
    // ************************************************************
    // Shadow only moves between words, so a word never sees a direction flip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_dir    <= 1'b0;
            pin_oe        <= 4'h0;
            pin_hw_ctrl   <= 1'b0;
            pin_push_pull <= 1'b0;
        end else begin
            if (state == ST_IDLE || word_done) begin
                shadow_dir <= shift_ctrl[`SC_DIR_BIT];
            end
            pin_oe        <= shadow_dir ? pin_mask(pdc_en) : 4'h0;
            pin_hw_ctrl   <= pdc_en != 2'b00;
            pin_push_pull <= pdc_en != 2'b00;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_copy_follows: assert property (word_done |=> copy_req ##1 buf_valid[$past(bank, 2)])
        else $error("finished word not copied");
    a_ready_wait: assert property (apb_first |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    a_shift_count: assert property (word_done |-> shift_cnt == 5'(wlen >> lg))
        else $error("word ended at wrong shift count");
    a_shadow_hold: assert property (state == ST_FRAME && !word_done |=> $stable(shadow_dir))
        else $error("direction moved inside a word");
    a_oe_off: assert property (pdc_en == 2'b00 |=> pin_oe == 4'h0 && !pin_hw_ctrl)
        else $error("pins driven without hardware control");
    a_fill_bound: assert property (fifo_on |-> rx_fill <= rx_depth)
        else $error("fifo fill above size");
    a_fifo_wrap: assert property (pop_fifo && !(wr_done && hit_rfc) |=>
                                  rx_rd_off == (($past(rx_rd_off) + 6'd1) & rx_mask))
        else $error("read pointer did not advance");
    a_merged_order: assert property (pop_merged |=> rd_bank != $past(rd_bank))
        else $error("merged view out of order");
    a_eof_tag: assert property (part_done && !word_done |=> ##1 copy_eof)
        else $error("frame end not tagged");

endmodule

// ---- logic/serial_rx_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes 32-bit APB data, one aligned word per register
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH
`define OFS_SHIFT_CTRL   12'h000
`define OFS_CHAN_CTRL    12'h004
`define OFS_CHAN_CFG     12'h008
`define OFS_RX_FIFO_CTRL 12'h00C
`define OFS_TX_FIFO_CTRL 12'h010
`define OFS_RX_MERGED    12'h014
`define OFS_RX_FIFO_OUT  12'h018
`define OFS_RX_STATUS    12'h01C
`define SC_LANE_LSB      0
`define SC_LANE_MSB      1
`define SC_ORDER_BIT     2
`define SC_DIR_BIT       3
`define SC_WLEN_LSB      4
`define SC_WLEN_MSB      7
`define CC_PDC_LSB       0
`define CC_PDC_MSB       1
`define FC_PTR_LSB       0
`define FC_PTR_MSB       5
`define FC_SIZE_LSB      8
`define FC_SIZE_MSB      10
`define FC_IRQ_LSB       16
`define FC_IRQ_MSB       23
`define SHIFT_CTRL_RESET 32'h0000_00F4
`define CTRL_RESET       32'h0000_0000
`define WORD_HOLD_CYCLES 4
`define FRAME_GAP_CYCLES 5
`endif

// ---- logic/serial_rx_pkg.sv ----
// Types shared by the receive path
// Assumes serial_rx_regs.svh for numeric constants
package serial_rx_pkg;
    typedef enum logic [1:0] {
        LANE_ONE  = 2'b00,
        LANE_TWO  = 2'b10,
        LANE_FOUR = 2'b11
    } lane_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FRAME = 2'b01
    } rx_state_t;
    typedef logic [20:0] fifo_entry_t;
endpackage

// ---- verif/serial_link_master.sv ----
// Serial master model: shift clock, frame control and four data lanes
// Assumes the receiver samples these pins on its own clock
`timescale 1ns/1ps
module serial_link_master (
    output logic       shift_clk_pin,
    output logic       shift_ctl_pin,
    output logic [3:0] data_pin_in
);
    initial begin
        shift_clk_pin = 1'b0;
        shift_ctl_pin = 1'b0;
        data_pin_in   = 4'h0;
    end
    // ****************************************
    // One word per frame, clock still between
    // ****************************************
    task automatic send(input logic [1:0] m, input logic msb, input logic [15:0] d, input int nb);
        int l;
        l = (m == 2'b11) ? 4 : (m == 2'b10) ? 2 : 1;
        #37 shift_ctl_pin = 1'b1;
        for (int n = 0; n < nb / l; n++) begin
            for (int k = 0; k < l; k++) begin
                data_pin_in[k] = msb ? d[15 - n * l - k] : d[n * l + k];
            end
            #80 shift_clk_pin = 1'b1;
            #80 shift_clk_pin = 1'b0;
        end
        shift_ctl_pin = 1'b0;
        // Released lanes never keep the last bit
        data_pin_in = ~data_pin_in;
        #200;
    endtask
endmodule

// ---- verif/serial_rx_path_tb_top.sv ----
// Self-checking bench for the receive path over APB and the serial pins
// Assumes the design package and register header are compiled first
`timescale 1ns/1ps
`include "serial_rx_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module serial_rx_path_tb_top;
    import serial_rx_pkg::*;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic        pready, pslverr, err, shift_clk_pin, shift_ctl_pin, pin_hw_ctrl, pin_push_pull;
    logic [3:0]  data_pin_in, pin_oe;
    logic [15:0] w [3];
    logic [1:0]  m;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          seed = 83;
    always #2 pclk = ~pclk;
    serial_rx_path DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shift_clk_pin(shift_clk_pin), .shift_ctl_pin(shift_ctl_pin),
        .data_pin_in(data_pin_in), .pin_oe(pin_oe), .pin_hw_ctrl(pin_hw_ctrl),
        .pin_push_pull(pin_push_pull));
    serial_link_master lk (.shift_clk_pin(shift_clk_pin), .shift_ctl_pin(shift_ctl_pin),
        .data_pin_in(data_pin_in));
    function automatic fifo_entry_t exp_entry(input logic [15:0] d);
        return {1'b0, 4'hF, d};
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #200_000;
        num_errors++;
        test_done();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `OFS_SHIFT_CTRL, 0);
        `CHK("shift ctrl", `SHIFT_CTRL_RESET, q)
        apb(0, `OFS_CHAN_CFG, 0);
        `CHK("config", 2'b11, q[1:0])
        apb(0, 12'h0FC, 0);
        `CHK("unmapped", 1'b1, err)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            m = (i % 3 == 0) ? 2'b00 : (i % 3 == 1) ? 2'b10 : 2'b11;
            apb(1, `OFS_SHIFT_CTRL, {24'h0, 4'hF, 1'b0, i >= 3, m});
            w[0] = (i == 0) ? 16'h8001 : 16'($random(seed));
            w[1] = 16'($random(seed));
            lk.send(m, i >= 3, w[0], 16);
            lk.send(m, i >= 3, w[1], 16);
            apb(0, `OFS_RX_MERGED, 0);
            `CHK("merged a", {1'b1, exp_entry(w[0])}, {q[31], q[20:0]})
            apb(0, `OFS_RX_MERGED, 0);
            `CHK("merged b", {1'b1, exp_entry(w[1])}, {q[31], q[20:0]})
        end
        apb(0, `OFS_RX_MERGED, 0);
        `CHK("merged empty", 1'b0, q[31])
        // Frame cut after eight bits must land as a partial word tagged end of frame
        apb(1, `OFS_SHIFT_CTRL, 32'h0000_00F0);
        w[0] = 16'($random(seed));
        lk.send(2'b00, 1'b0, w[0], 8);
        apb(0, `OFS_RX_MERGED, 0);
        `CHK("partial", {2'b11, 4'h7, 8'h00, w[0][7:0]}, {q[31], q[20:0]})
        $display("test lanes done");
        apb(1, `OFS_RX_FIFO_CTRL, 32'h0000_0208);
        apb(1, `OFS_SHIFT_CTRL, 32'h0000_00F3);
        for (int r = 0; r < 2; r++) begin
            for (int j = 0; j < 3; j++) begin
                w[j] = 16'($random(seed));
                lk.send(2'b11, 1'b0, w[j], 16);
            end
            for (int j = 0; j < 3; j++) begin
                apb(0, `OFS_RX_FIFO_OUT, 0);
                `CHK("fifo out", {1'b1, exp_entry(w[j])}, {q[31], q[20:0]})
            end
            apb(0, `OFS_RX_FIFO_OUT, 0);
            `CHK("fifo empty", 1'b0, q[31])
        end
        apb(1, `OFS_RX_FIFO_CTRL, 32'h00A5_0300);
        apb(0, `OFS_RX_FIFO_CTRL, 0);
        `CHK("fifo ctrl", 24'hA5_0208, q[23:0])
        apb(1, `OFS_RX_FIFO_CTRL, 32'h0000_0000);
        $display("test fifo done");
        for (int e = 0; e < 4; e++) begin
            apb(1, `OFS_CHAN_CTRL, e);
            apb(1, `OFS_SHIFT_CTRL, 32'h0000_00F8);
            repeat (3) @(posedge pclk);
            `CHK("pin oe", (e == 0) ? 4'h0 : (e == 1) ? 4'h1 : (e == 2) ? 4'h3 : 4'hF,
                pin_oe)
            `CHK("hw ctrl", e != 0, pin_hw_ctrl)
            `CHK("push pull", e != 0, pin_push_pull)
        end
        fork
            lk.send(2'b00, 1'b0, 16'h1234, 16);
            begin
                repeat (100) @(posedge pclk);
                apb(1, `OFS_SHIFT_CTRL, 32'h0000_00F0);
                `CHK("oe held", 4'hF, pin_oe)
            end
        join
        repeat (3) @(posedge pclk);
        `CHK("oe after word", 4'h0, pin_oe)
        $display("test direction done");
        test_done();
    end
endmodule
